// ### verilog/sc_pkg.sv
package sc_pkg;
  // command codes seen as the two command bytes of a write frame
  localparam logic [15:0] SC_CMD_CLEAR_STATUS = 16'h3041;
  localparam logic [15:0] SC_CMD_HEATER_ON = 16'h306D;
  localparam logic [15:0] SC_CMD_HEATER_OFF = 16'h3066;
  localparam logic [15:0] SC_CMD_READ_STATUS = 16'hF32D;
  localparam logic [15:0] SC_CMD_FETCH_MEAS = 16'hE000;
  // status word field positions
  localparam int SC_BIT_ALERT_PEND = 15;
  localparam int SC_BIT_HEATER = 13;
  localparam int SC_BIT_HUM_ALERT = 11;
  localparam int SC_BIT_TEMP_ALERT = 10;
  localparam int SC_BIT_RESET_SEEN = 4;
  localparam int SC_BIT_CMD_FAIL = 1;
  localparam int SC_BIT_WR_CRC_FAIL = 0;
  // values after reset
  localparam logic SC_RST_ALERT_PEND = 1'b1;
  localparam logic SC_RST_HEATER = 1'b0;
  localparam logic SC_RST_HUM_ALERT = 1'b0;
  localparam logic SC_RST_TEMP_ALERT = 1'b0;
  localparam logic SC_RST_RESET_SEEN = 1'b1;
  localparam logic SC_RST_CMD_FAIL = 1'b0;
  localparam logic SC_RST_WR_CRC_FAIL = 1'b0;
  // checksum properties
  localparam logic [7:0] SC_CRC_POLY = 8'h31;
  localparam logic [7:0] SC_CRC_INIT = 8'hFF;
  localparam logic [7:0] SC_CRC_FINAL_XOR = 8'h00;
  // frame byte counts, last read index and idle byte
  localparam logic [2:0] SC_LEN_CMD = 3'h2;
  localparam logic [2:0] SC_LEN_CMD_DATA = 3'h5;
  localparam logic [2:0] SC_LEN_OVER = 3'h6;
  localparam logic [2:0] SC_RD_LAST = 3'h7;
  localparam logic [7:0] SC_IDLE_BYTE = 8'hFF;
  // source of the bytes a host reads
  typedef enum logic [1:0] {SC_RD_NONE, SC_RD_STATUS, SC_RD_MEAS} sc_rd_src_t;
endpackage : sc_pkg

// ### verilog/sc_crc8.sv
`timescale 1ns/1ns
`default_nettype none
// registered checksum of one 16-bit word, one cycle of latency
module sc_crc8 (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] word,
  output logic [7:0] crc
);
  import sc_pkg::*;

  logic [7:0] crc_r; // registered checksum
  logic [7:0] crc_nxt; // checksum of the present word

  // msb-first shift over both bytes, no reflection
  function automatic logic [7:0] sc_crc_word(input logic [15:0] w);
    logic [7:0] c;
    logic fb;
    c = SC_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      fb = c[7] ^ w[i];
      c = {c[6:0], 1'b0} ^ (fb ? SC_CRC_POLY : 8'h00);
    end
    return c ^ SC_CRC_FINAL_XOR;
  endfunction : sc_crc_word

  // next value, over the two bytes only
  always_comb begin
    crc_nxt = sc_crc_word(word);
  end

  // register
  always_ff @(posedge clk) begin
    if (rst) begin
      crc_r <= SC_CRC_INIT;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crc = crc_r;
endmodule : sc_crc8
`default_nettype wire

// ### verilog/sc_status.sv
`timescale 1ns/1ns
`default_nettype none
module sc_status (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_start,
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  input wire logic wr_stop,
  input wire logic rd_start,
  input wire logic rd_req,
  output logic [7:0] rd_byte,
  input wire logic soft_reset,
  input wire logic supply_fail,
  input wire logic hum_alert,
  input wire logic temp_alert,
  input wire logic meas_valid,
  input wire logic [15:0] raw_humidity_code,
  input wire logic [15:0] raw_temperature_code,
  input wire logic cmd_known,
  output logic [15:0] cmd_word,
  output logic [15:0] cmd_data,
  output logic cmd_strobe,
  output logic heater_on,
  output logic [15:0] status_word
);
  import sc_pkg::*;

  // status flags
  logic pend_r, pend_nxt; // alert pending
  logic heat_r, heat_nxt; // heater on
  logic hal_r, hal_nxt; // humidity tracking alert
  logic tal_r, tal_nxt; // temperature tracking alert
  logic rsf_r, rsf_nxt; // reset detected
  logic cmdf_r, cmdf_nxt; // last command rejected
  logic wcf_r, wcf_nxt; // last write checksum failed
  // write frame capture
  logic [7:0] wb_r [0:4]; // received bytes
  logic [7:0] wb_nxt [0:4];
  logic [2:0] wcnt_r, wcnt_nxt; // bytes in frame, saturates
  logic strobe_r, strobe_nxt; // command handed on
  // read side
  sc_rd_src_t src_r, src_nxt; // what the host reads
  logic [15:0] rw0_r, rw0_nxt; // first word to send
  logic [15:0] rw1_r, rw1_nxt; // second word to send
  logic [2:0] ridx_r, ridx_nxt; // next byte index
  logic [7:0] rbyte_r, rbyte_nxt; // byte on the read port
  // measurements
  logic [15:0] hum_r, hum_nxt; // last humidity code
  logic [15:0] temp_r, temp_nxt; // last temperature code
  // checksums
  logic [7:0] wr_crc; // over written data word
  logic [7:0] rw0_crc; // over first read word
  logic [7:0] rw1_crc; // over second read word
  logic [15:0] status; // assembled status word
  logic [15:0] cword; // command bytes

  assign cword = {wb_r[0], wb_r[1]};

  // status word layout, reserved bits at zero
  always_comb begin
    status = 16'h0000;
    status[SC_BIT_ALERT_PEND] = pend_r;
    status[SC_BIT_HEATER] = heat_r;
    status[SC_BIT_HUM_ALERT] = hal_r;
    status[SC_BIT_TEMP_ALERT] = tal_r;
    status[SC_BIT_RESET_SEEN] = rsf_r;
    status[SC_BIT_CMD_FAIL] = cmdf_r;
    status[SC_BIT_WR_CRC_FAIL] = wcf_r;
  end

  // checksum of the written data word
  sc_crc8 u_crc_wr (
    .clk(clk),
    .rst(rst),
    .word({wb_r[2], wb_r[3]}),
    .crc(wr_crc)
  );

  // checksum of the first word read out
  sc_crc8 u_crc_rd0 (
    .clk(clk),
    .rst(rst),
    .word(rw0_r),
    .crc(rw0_crc)
  );

  // checksum of the second word read out
  sc_crc8 u_crc_rd1 (
    .clk(clk),
    .rst(rst),
    .word(rw1_r),
    .crc(rw1_crc)
  );

  // pick the read byte for an index: word msb, lsb, checksum
  function automatic logic [7:0] sc_rd_pick(input sc_rd_src_t s, input logic [2:0] idx,
                                           input logic [15:0] w0, input logic [7:0] c0,
                                           input logic [15:0] w1, input logic [7:0] c1);
    logic [7:0] b;
    b = SC_IDLE_BYTE;
    if (s != SC_RD_NONE) begin
      case (idx)
        3'h0: b = w0[15:8];
        3'h1: b = w0[7:0];
        3'h2: b = c0;
        3'h3: b = (s == SC_RD_MEAS) ? w1[15:8] : SC_IDLE_BYTE;
        3'h4: b = (s == SC_RD_MEAS) ? w1[7:0] : SC_IDLE_BYTE;
        3'h5: b = (s == SC_RD_MEAS) ? c1 : SC_IDLE_BYTE;
        default: b = SC_IDLE_BYTE;
      endcase
    end
    return b;
  endfunction : sc_rd_pick

  // next state of flags, frame capture and read side
  always_comb begin
    pend_nxt = pend_r;
    heat_nxt = heat_r;
    hal_nxt = hal_r;
    tal_nxt = tal_r;
    rsf_nxt = rsf_r;
    cmdf_nxt = cmdf_r;
    wcf_nxt = wcf_r;
    for (int i = 0; i < 5; i++) begin
      wb_nxt[i] = wb_r[i];
    end
    wcnt_nxt = wcnt_r;
    strobe_nxt = 1'b0;
    src_nxt = src_r;
    rw0_nxt = rw0_r;
    rw1_nxt = rw1_r;
    ridx_nxt = ridx_r;
    rbyte_nxt = rbyte_r;
    hum_nxt = hum_r;
    temp_nxt = temp_r;
    // new write frame
    if (wr_start) begin
      wcnt_nxt = 3'h0;
    end else if (wr_valid) begin
      // store a byte, count saturates past the longest frame
      if (wcnt_r < SC_LEN_CMD_DATA) begin
        wb_nxt[wcnt_r] = wr_byte;
      end
      if (wcnt_r != SC_LEN_OVER) begin
        wcnt_nxt = wcnt_r + 3'h1;
      end
    end else if (wr_stop) begin
      // execute the frame
      if (wcnt_r == SC_LEN_CMD) begin
        cmdf_nxt = 1'b0;
        if (cword == SC_CMD_CLEAR_STATUS) begin
          pend_nxt = 1'b0;
          hal_nxt = 1'b0;
          tal_nxt = 1'b0;
          rsf_nxt = 1'b0;
        end else if (cword == SC_CMD_HEATER_ON) begin
          heat_nxt = 1'b1;
        end else if (cword == SC_CMD_HEATER_OFF) begin
          heat_nxt = 1'b0;
        end else if (cword == SC_CMD_READ_STATUS) begin
          src_nxt = SC_RD_STATUS;
          rw0_nxt = status;
        end else if (cword == SC_CMD_FETCH_MEAS) begin
          src_nxt = SC_RD_MEAS;
          rw0_nxt = temp_r;
          rw1_nxt = hum_r;
        end else if (cmd_known) begin
          strobe_nxt = 1'b1;
        end else begin
          cmdf_nxt = 1'b1;
        end
      end else if (wcnt_r == SC_LEN_CMD_DATA) begin
        // command with one protected data word
        wcf_nxt = (wr_crc != wb_r[4]);
        cmdf_nxt = (wr_crc != wb_r[4]) || !cmd_known;
        strobe_nxt = (wr_crc == wb_r[4]) && cmd_known;
      end else begin
        cmdf_nxt = 1'b1;
      end
    end
    // sticky events after the clear, so a set wins
    if (hum_alert) begin
      hal_nxt = 1'b1;
      pend_nxt = 1'b1;
    end
    if (temp_alert) begin
      tal_nxt = 1'b1;
      pend_nxt = 1'b1;
    end
    if (supply_fail) begin
      rsf_nxt = 1'b1;
    end
    // measurement capture
    if (meas_valid) begin
      hum_nxt = raw_humidity_code;
      temp_nxt = raw_temperature_code;
    end
    // read byte stream
    if (rd_start) begin
      ridx_nxt = 3'h0;
    end else if (rd_req) begin
      rbyte_nxt = sc_rd_pick(src_r, ridx_r, rw0_r, rw0_crc, rw1_r, rw1_crc);
      if (ridx_r != SC_RD_LAST) begin
        ridx_nxt = ridx_r + 3'h1;
      end
    end
    // soft reset returns the flags, read source, frame count and strobe to defaults but marks the reset
    if (soft_reset) begin
      pend_nxt = SC_RST_ALERT_PEND;
      heat_nxt = SC_RST_HEATER;
      hal_nxt = SC_RST_HUM_ALERT;
      tal_nxt = SC_RST_TEMP_ALERT;
      rsf_nxt = 1'b1;
      cmdf_nxt = SC_RST_CMD_FAIL;
      wcf_nxt = SC_RST_WR_CRC_FAIL;
      src_nxt = SC_RD_NONE;
      wcnt_nxt = 3'h0;
      strobe_nxt = 1'b0;
    end
  end

  // register everything
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_r <= SC_RST_ALERT_PEND;
      heat_r <= SC_RST_HEATER;
      hal_r <= SC_RST_HUM_ALERT;
      tal_r <= SC_RST_TEMP_ALERT;
      rsf_r <= SC_RST_RESET_SEEN;
      cmdf_r <= SC_RST_CMD_FAIL;
      wcf_r <= SC_RST_WR_CRC_FAIL;
      for (int i = 0; i < 5; i++) begin
        wb_r[i] <= 8'h00;
      end
      wcnt_r <= 3'h0;
      strobe_r <= 1'b0;
      src_r <= SC_RD_NONE;
      rw0_r <= 16'h0000;
      rw1_r <= 16'h0000;
      ridx_r <= 3'h0;
      rbyte_r <= SC_IDLE_BYTE;
      hum_r <= 16'h0000;
      temp_r <= 16'h0000;
    end else begin
      pend_r <= pend_nxt;
      heat_r <= heat_nxt;
      hal_r <= hal_nxt;
      tal_r <= tal_nxt;
      rsf_r <= rsf_nxt;
      cmdf_r <= cmdf_nxt;
      wcf_r <= wcf_nxt;
      for (int i = 0; i < 5; i++) begin
        wb_r[i] <= wb_nxt[i];
      end
      wcnt_r <= wcnt_nxt;
      strobe_r <= strobe_nxt;
      src_r <= src_nxt;
      rw0_r <= rw0_nxt;
      rw1_r <= rw1_nxt;
      ridx_r <= ridx_nxt;
      rbyte_r <= rbyte_nxt;
      hum_r <= hum_nxt;
      temp_r <= temp_nxt;
    end
  end

  // outputs
  assign rd_byte = rbyte_r;
  assign cmd_word = cword;
  assign cmd_data = {wb_r[2], wb_r[3]};
  assign cmd_strobe = strobe_r;
  assign heater_on = heat_r;
  assign status_word = status;
endmodule : sc_status
`default_nettype wire

// ### testbench/sc_status_properties.sv
`timescale 1ns/1ns
`default_nettype none
// watches the status block's ports for the flag and command rules
module sc_status_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_stop,
  input wire logic soft_reset,
  input wire logic supply_fail,
  input wire logic hum_alert,
  input wire logic temp_alert,
  input wire logic [15:0] cmd_word,
  input wire logic cmd_strobe,
  input wire logic heater_on,
  input wire logic [15:0] status_word
);
  import sc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_hum_alert: assert property (hum_alert && !soft_reset |=> status_word[15] && status_word[11])
    else $error("humidity alert not flagged");
  a_temp_alert: assert property (temp_alert && !soft_reset |=> status_word[15] && status_word[10])
    else $error("temperature alert not flagged");
  a_heater_mirror: assert property (heater_on == status_word[13])
    else $error("heater bit differs from heater state");
  a_soft_reset: assert property (soft_reset |=> status_word == 16'h8010 && !heater_on)
    else $error("soft reset did not restore defaults");
  a_supply_flag: assert property (supply_fail |=> status_word[4])
    else $error("supply fail not flagged");
  // clear zeroes bits 15, 11, 10, 4 and reports success in bit 1
  a_clear_flags: assert property (wr_stop && !(soft_reset || supply_fail || hum_alert || temp_alert)
    ##1 cmd_word == SC_CMD_CLEAR_STATUS |-> (status_word & 16'h8C12) == 16'h0000)
    else $error("clear command left a flag set");
  // heater codes differ in bit 3 of the low byte: on has it set
  a_heater_cmd: assert property (wr_stop && !soft_reset ##1
    (cmd_word == SC_CMD_HEATER_ON || cmd_word == SC_CMD_HEATER_OFF) |-> heater_on == cmd_word[3])
    else $error("heater command not obeyed");
  a_reserved_zero: assert property ((status_word & 16'h53EC) == 16'h0000)
    else $error("reserved status bit set");
  a_strobe_cause: assert property (cmd_strobe |-> $past(wr_stop) && !status_word[1])
    else $error("strobe without accepted frame");
endmodule : sc_status_properties
bind sc_status sc_status_properties i_props (.clk, .rst, .wr_stop, .soft_reset, .supply_fail,
  .hum_alert, .temp_alert, .cmd_word, .cmd_strobe, .heater_on, .status_word);
`default_nettype wire

// ### testbench/sc_host.sv
`timescale 1ns/1ns
`default_nettype none
// host side: drives write and read frames at byte level
module sc_host (
  input wire logic clk,
  input wire logic [7:0] rd_byte,
  output logic wr_start,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  output logic wr_stop,
  output logic rd_start,
  output logic rd_req
);
  import sc_pkg::*;
  logic [7:0] got [0:5]; // bytes of the last read
  initial begin
    {wr_start, wr_valid, wr_stop, rd_start, rd_req} = 5'h00;
    wr_byte = 8'h00;
  end
  // checksum of one word, msb first, no reflection
  function automatic logic [7:0] crc(input logic [15:0] w);
    logic [7:0] c;
    c = SC_CRC_INIT;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? SC_CRC_POLY : 8'h00);
    return c ^ SC_CRC_FINAL_XOR;
  endfunction : crc
  // host scaling of a humidity code to whole percent
  function automatic int rh_pct(input logic [15:0] s);
    return 100 * int'(s) / 65535;
  endfunction : rh_pct
  // host scaling of a temperature code to whole degrees, celsius or fahrenheit
  function automatic int t_deg(input logic [15:0] s, input logic fahr);
    return fahr ? -49 + 315 * int'(s) / 65535 : -45 + 175 * int'(s) / 65535;
  endfunction : t_deg
  // one written byte; valid stays up so back-to-back bytes run with no idle cycle between
  task automatic put(input logic [7:0] b);
    wr_valid = 1'b1;
    wr_byte = b;
    @(posedge clk);
    #1;
  endtask : put
  // command frame, with data word and checksum when five is set
  task automatic send(input logic [15:0] c, input logic five, input logic [15:0] d, input logic bad);
    wr_start = 1'b1;
    @(posedge clk);
    #1;
    wr_start = 1'b0;
    put(c[15:8]);
    put(c[7:0]);
    if (five) begin
      put(d[15:8]);
      put(d[7:0]);
      put(crc(d) ^ {7'h00, bad});
    end
    // line released; it shows the inverse, not a stale value
    wr_valid = 1'b0;
    wr_byte = ~wr_byte;
    if (five) begin
      @(posedge clk); // checksum latency before stop
      #1;
    end
    wr_stop = 1'b1;
    @(posedge clk);
    #1;
    wr_stop = 1'b0;
  endtask : send
  // read frame of n bytes, request held high across them
  task automatic fetch(input int n);
    rd_start = 1'b1;
    @(posedge clk);
    #1;
    rd_start = 1'b0;
    rd_req = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      got[i] = rd_byte;
      if (i == n - 1) rd_req = 1'b0;
    end
  endtask : fetch
endmodule : sc_host
`default_nettype wire

// ### testbench/sc_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sc_status_tb;
  import sc_pkg::*;
  typedef struct {logic [15:0] c; logic five; logic [15:0] d; logic bad; logic known;
    logic [15:0] st; logic stb;} sc_row_t;
  logic clk, rst, wr_start, wr_valid, wr_stop, rd_start, rd_req, soft_reset, supply_fail;
  logic hum_alert, temp_alert, meas_valid, cmd_known, cmd_strobe, heater_on;
  logic [7:0] wr_byte, rd_byte;
  logic [15:0] raw_humidity_code, raw_temperature_code, cmd_word, cmd_data, status_word;
  int failures = 0, n_tests = 0, cycles = 0;
  // command, five-byte, data, bad crc, outside ack, status after, strobe
  sc_row_t rows [8] = '{
    '{16'h3041, 1'b0, 16'h0000, 1'b0, 1'b0, 16'h0000, 1'b0},
    '{16'h306D, 1'b0, 16'h0000, 1'b0, 1'b0, 16'h2000, 1'b0},
    '{16'h1234, 1'b0, 16'h0000, 1'b0, 1'b0, 16'h2002, 1'b0},
    '{16'h3066, 1'b0, 16'h0000, 1'b0, 1'b0, 16'h0000, 1'b0},
    '{16'h1234, 1'b1, 16'hBEEF, 1'b0, 1'b1, 16'h0000, 1'b1},
    '{16'h1234, 1'b1, 16'hBEEF, 1'b1, 1'b1, 16'h0003, 1'b0},
    '{16'hABCD, 1'b1, 16'h0102, 1'b0, 1'b0, 16'h0002, 1'b0},
    '{16'h1234, 1'b0, 16'h0000, 1'b0, 1'b1, 16'h0000, 1'b1}};
  sc_status i_dut (.clk(clk), .rst(rst), .wr_start(wr_start), .wr_valid(wr_valid), .wr_byte(wr_byte),
    .wr_stop(wr_stop), .rd_start(rd_start), .rd_req(rd_req), .rd_byte(rd_byte), .soft_reset(soft_reset),
    .supply_fail(supply_fail), .hum_alert(hum_alert), .temp_alert(temp_alert), .meas_valid(meas_valid),
    .raw_humidity_code(raw_humidity_code), .raw_temperature_code(raw_temperature_code),
    .cmd_known(cmd_known), .cmd_word(cmd_word), .cmd_data(cmd_data), .cmd_strobe(cmd_strobe),
    .heater_on(heater_on), .status_word(status_word));
  sc_host i_host (.clk(clk), .rd_byte(rd_byte), .wr_start(wr_start), .wr_valid(wr_valid),
    .wr_byte(wr_byte), .wr_stop(wr_stop), .rd_start(rd_start), .rd_req(rd_req));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : check
  // one-cycle pulse on an event input, then status check
  task automatic event_pulse(input int k, input logic [15:0] e);
    {hum_alert, temp_alert, supply_fail, soft_reset} = 4'h8 >> k;
    tick();
    {hum_alert, temp_alert, supply_fail, soft_reset} = 4'h0;
    check(status_word, e);
    tick(); // let an edge pass before the next pulse
  endtask : event_pulse
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial begin
    {rst, soft_reset, supply_fail, hum_alert, temp_alert, meas_valid, cmd_known} = 7'h40;
    raw_humidity_code = 16'hBEEF;
    raw_temperature_code = 16'h6666;
    repeat (6) @(posedge clk);
    #1;
    check(status_word, 16'h8010);
    check({8'h00, rd_byte}, 16'h00FF);
    check({15'h0000, cmd_strobe}, 16'h0000);
    rst = 1'b0;
    foreach (rows[i]) begin
      cmd_known = rows[i].known;
      i_host.send(rows[i].c, rows[i].five, rows[i].d, rows[i].bad);
      check(status_word, rows[i].st);
      check({15'h0000, cmd_strobe}, {15'h0000, rows[i].stb});
      check({15'h0000, heater_on}, {15'h0000, rows[i].st[13]});
      check(cmd_word, rows[i].c);
    end
    // a two-byte frame leaves the data word of the last five-byte frame
    check(cmd_data, 16'h0102);
    event_pulse(0, 16'h8800);
    event_pulse(1, 16'h8C00);
    i_host.send(SC_CMD_CLEAR_STATUS, 1'b0, 16'h0000, 1'b0);
    check(status_word, 16'h0000);
    event_pulse(2, 16'h0010);
    i_host.send(SC_CMD_HEATER_ON, 1'b0, 16'h0000, 1'b0);
    event_pulse(3, 16'h8010);
    check({15'h0000, heater_on}, 16'h0000);
    i_host.send(SC_CMD_READ_STATUS, 1'b0, 16'h0000, 1'b0);
    tick();
    tick();
    i_host.fetch(4);
    check({i_host.got[0], i_host.got[1]}, 16'h8010);
    check({i_host.got[2], i_host.got[3]}, {i_host.crc(16'h8010), 8'hFF});
    meas_valid = 1'b1;
    tick();
    meas_valid = 1'b0;
    i_host.send(SC_CMD_FETCH_MEAS, 1'b0, 16'h0000, 1'b0);
    tick();
    tick();
    i_host.fetch(6);
    check({i_host.got[0], i_host.got[1]}, 16'h6666);
    check({i_host.got[2], i_host.got[3]}, {i_host.crc(16'h6666), 8'hBE});
    check({i_host.got[4], i_host.got[5]}, {8'hEF, i_host.crc(16'hBEEF)});
    check({8'h00, i_host.crc(16'hBEEF)}, 16'h0092);
    check(16'(i_host.rh_pct({i_host.got[3], i_host.got[4]})), 16'h004A);
    check(16'(i_host.t_deg({i_host.got[0], i_host.got[1]}, 1'b0)), 16'h0019);
    check(16'(i_host.t_deg({i_host.got[0], i_host.got[1]}, 1'b1)), 16'h004D);
    // hard reset in mid-run after the flags were cleared
    i_host.send(SC_CMD_CLEAR_STATUS, 1'b0, 16'h0000, 1'b0);
    i_host.send(SC_CMD_HEATER_ON, 1'b0, 16'h0000, 1'b0);
    check(status_word, 16'h2000);
    rst = 1'b1;
    tick();
    check(status_word, 16'h8010);
    check({8'h00, rd_byte}, 16'h00FF);
    rst = 1'b0;
    // first frame right after release
    i_host.send(SC_CMD_HEATER_ON, 1'b0, 16'h0000, 1'b0);
    check(status_word, 16'hA010);
    close_out();
  end
endmodule : sc_status_tb
`default_nettype wire
